/* include/drive_pkg.sv */
package drive_pkg;

  // Clock rate and contact filter time
  localparam int CLK_FREQ_HZ       = 50_000_000;
  localparam int DEBOUNCE_TIME_US  = 10_000;
  localparam int DEBOUNCE_CYCLES   =
    (DEBOUNCE_TIME_US * (CLK_FREQ_HZ / 1_000_000));

  // Width of setting codes and preset speed values
  localparam int CODE_W            = 8;
  localparam int SPEED_W           = 16;
  localparam int NUM_PRESETS       = 7;

  // Rotation direction setting
  localparam logic [7:0] DIR_FWD_AND_REV   = 8'h02;

  // Select input function codes
  localparam logic [7:0] SEL_VOLTAGE_REF   = 8'h02;
  localparam logic [7:0] SEL_CURRENT_REF   = 8'h03;
  localparam logic [7:0] SEL_PRESET        = 8'h04;
  localparam logic [7:0] SEL_RUN_REVERSE   = 8'h05;
  localparam logic [7:0] SEL_START_REVERSE = 8'h06;

  // Standard speed source codes
  localparam logic [7:0] STD_SRC_PRESET1   = 8'h02;
  localparam logic [7:0] STD_SRC_VOLTAGE   = 8'h03;
  localparam logic [7:0] STD_SRC_CURRENT   = 8'h04;

  // Wiring scheme selection
  localparam logic [1:0] SCHEME_TWO_WIRE   = 2'h0;
  localparam logic [1:0] SCHEME_FWD_REV    = 2'h1;
  localparam logic [1:0] SCHEME_THREE_WIRE = 2'h2;

  // Speed reference source reported at the output
  localparam logic [2:0] SRC_KEYPAD        = 3'h0;
  localparam logic [2:0] SRC_VOLTAGE       = 3'h1;
  localparam logic [2:0] SRC_CURRENT       = 3'h2;
  localparam logic [2:0] SRC_PRESET        = 3'h3;

  // Reset values and the preset one index
  localparam logic       PIN_OPEN_LEVEL    = 1'b1;
  localparam logic [2:0] PRESET_IDX_NONE   = 3'h0;
  localparam logic [2:0] PRESET_IDX_ONE    = 3'h1;
  localparam logic [15:0] SPEED_RESET      = 16'h0000;

  // Latched run state of the momentary scheme
  typedef enum logic [2:0] {
    ST_STOPPED = 3'b001,
    ST_FWD     = 3'b010,
    ST_REV     = 3'b100
  } run_state_t;

endpackage : drive_pkg

/* rtl/contact_debounce.sv */
`timescale 1ns/1ps
`default_nettype none

module contact_debounce #(
  parameter int CYCLES = 16
) (
  input  wire logic CORE_CLK,
  input  wire logic RESET,
  input  wire logic CE,
  input  wire logic pin_n,
  output var  logic closed
);
  import drive_pkg::*;

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  logic             sync1_reg;
  logic             sync2_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             level;
  logic             differs;

  // Contact closed to common reads low
  assign level    = ~sync2_reg;
  assign differs  = (level != closed);
  assign cnt_next = differs ? (cnt_reg + 1'b1) : CNT_ZERO;

  // Two-stage synchroniser
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      sync1_reg <= PIN_OPEN_LEVEL;
      sync2_reg <= PIN_OPEN_LEVEL;
    end else if (CE) begin
      sync1_reg <= pin_n;
      sync2_reg <= sync1_reg;
    end
  end

  // Accept a new level only after it held steady
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cnt_reg <= CNT_ZERO;
      closed  <= 1'b0;
    end else if (CE) begin
      if (differs && cnt_reg == CNT_LAST) begin
        closed  <= level;
        cnt_reg <= CNT_ZERO;
      end else begin
        cnt_reg <= cnt_next;
      end
    end
  end

endmodule : contact_debounce

`default_nettype wire

/* rtl/drive_run_speed_select.sv */
// Behaviour
// R1: Basic two-wire: run while the stop contact is closed, stop when open.
// R2: Reverse in basic two-wire and three-wire needs direction 02, A 06.
// R3: Basic two-wire without reverse has the start contact tied to common.
// R4: A closed select coded 02 or 03 picks voltage or current reference.
// R5: The standard speed source takes 03 for voltage and 04 for current.
// R6: The forward/reverse two-wire scheme needs select A coded 05.
// R7: Forward/reverse scheme: run forward while the start contact is closed.
// R8: Forward/reverse scheme: A closed runs reverse, both closed stop.
// R9: Three-wire: a start pulse starts, a stop opening stops, run is latched.
// R10: Three-wire: the direction is taken only at a start pulse.
// R11: Selects coded 04 act as preset selects one to three.
// R12: With reverse in use only B and C act as preset selects.
// R13: With standard source 03 the pot is followed when no preset is closed.
// R14: Seven preset speed values are held and picked by select combination.
// R15: Among closed speed-reference selects the higher letter takes priority.
// R16: Every contact input is synchronised and debounced before use.
`timescale 1ns/1ps
`default_nettype none

module drive_run_speed_select #(
  parameter int DEBOUNCE_CYCLES = drive_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic                         CORE_CLK,
  input  wire logic                         RESET,
  input  wire logic                         CE,
  input  wire logic                         STOP_CONTACT_INPUT_N,
  input  wire logic                         START_CONTACT_INPUT_N,
  input  wire logic                         SELECT_INPUT_A_N,
  input  wire logic                         SELECT_INPUT_B_N,
  input  wire logic                         SELECT_INPUT_C_N,
  input  wire logic [1:0]                   WIRING_SCHEME,
  input  wire logic [drive_pkg::CODE_W-1:0] ROTATION_DIRECTION,
  input  wire logic [drive_pkg::CODE_W-1:0] STD_SPEED_SOURCE,
  input  wire logic [drive_pkg::CODE_W-1:0] SELECT_A_FUNCTION,
  input  wire logic [drive_pkg::CODE_W-1:0] SELECT_B_FUNCTION,
  input  wire logic [drive_pkg::CODE_W-1:0] SELECT_C_FUNCTION,
  input  wire logic [drive_pkg::SPEED_W-1:0] PRESET_SPEED_1,
  input  wire logic [drive_pkg::SPEED_W-1:0] PRESET_SPEED_2,
  input  wire logic [drive_pkg::SPEED_W-1:0] PRESET_SPEED_3,
  input  wire logic [drive_pkg::SPEED_W-1:0] PRESET_SPEED_4,
  input  wire logic [drive_pkg::SPEED_W-1:0] PRESET_SPEED_5,
  input  wire logic [drive_pkg::SPEED_W-1:0] PRESET_SPEED_6,
  input  wire logic [drive_pkg::SPEED_W-1:0] PRESET_SPEED_7,
  output var  logic                         RUN_CMD,
  output var  logic                         REVERSE_CMD,
  output var  logic [2:0]                   SPEED_SOURCE,
  output var  logic [2:0]                   PRESET_INDEX,
  output var  logic [drive_pkg::SPEED_W-1:0] PRESET_SPEED_OUT
);
  import drive_pkg::*;

  localparam int NUM_CONTACTS = 5;
  localparam int IDX_STOP     = 0;
  localparam int IDX_START    = 1;
  localparam int IDX_A        = 2;
  localparam int IDX_B        = 3;
  localparam int IDX_C        = 4;

  logic [NUM_CONTACTS-1:0] pins_n;
  logic [NUM_CONTACTS-1:0] closed;

  logic                    stop_closed;
  logic                    start_closed;
  logic                    a_closed;
  logic                    b_closed;
  logic                    c_closed;
  logic                    start_prev_reg;
  logic                    start_pulse;

  logic                    rev_allowed;
  logic                    a_start_rev;
  logic                    a_run_rev;
  logic                    two_run;
  logic                    two_rev;
  logic                    fr_fwd;
  logic                    fr_rev;
  logic                    three_rev_req;
  logic                    three_sel;

  run_state_t              state_reg;
  run_state_t              state_next;

  logic                    run_next;
  logic                    rev_next;

  logic                    a_volt;
  logic                    a_curr;
  logic                    a_pre;
  logic                    b_volt;
  logic                    b_curr;
  logic                    b_pre;
  logic                    c_volt;
  logic                    c_curr;
  logic                    c_pre;
  logic                    a_ref;
  logic                    b_ref;
  logic                    c_ref;
  logic [2:0]              preset_combo;
  logic [2:0]              std_src;
  logic [2:0]              std_idx;
  logic [2:0]              src_next;
  logic [2:0]              idx_next;
  logic [SPEED_W-1:0]      speed_next;
  logic [SPEED_W-1:0]      preset_tab [NUM_PRESETS:0];

  // Contact pins gathered for the filter loop
  assign pins_n[IDX_STOP]  = STOP_CONTACT_INPUT_N;
  assign pins_n[IDX_START] = START_CONTACT_INPUT_N;
  assign pins_n[IDX_A]     = SELECT_INPUT_A_N;
  assign pins_n[IDX_B]     = SELECT_INPUT_B_N;
  assign pins_n[IDX_C]     = SELECT_INPUT_C_N;

  // One synchroniser and debounce filter per contact
  generate
    for (genvar i = 0; i < NUM_CONTACTS; i++) begin : g_contact
      contact_debounce #(
        .CYCLES (DEBOUNCE_CYCLES)
      ) u_deb (
        .CORE_CLK (CORE_CLK),
        .RESET    (RESET),
        .CE       (CE),
        .pin_n    (pins_n[i]),
        .closed   (closed[i])                             // R16
      );
    end
  endgenerate

  assign stop_closed  = closed[IDX_STOP];
  assign start_closed = closed[IDX_START];
  assign a_closed     = closed[IDX_A];
  assign b_closed     = closed[IDX_B];
  assign c_closed     = closed[IDX_C];

  // Start pulse on the filtered closing edge
  assign start_pulse = start_closed & ~start_prev_reg;

  // Reverse permission and select A direction roles
  assign rev_allowed = (ROTATION_DIRECTION == DIR_FWD_AND_REV);
  assign a_start_rev = rev_allowed &&
                       (SELECT_A_FUNCTION == SEL_START_REVERSE); // R2
  assign a_run_rev   = (SELECT_A_FUNCTION == SEL_RUN_REVERSE);

  // Basic two-wire: stop contact held closed means run
  assign two_run = stop_closed &&
                   (start_closed || (a_start_rev && a_closed)); // R1
  assign two_rev = a_start_rev && a_closed;                   // R2

  // Forward/reverse two-wire: exclusive closures, both stop
  assign fr_fwd = start_closed && !a_closed;                  // R7
  assign fr_rev = a_run_rev && rev_allowed &&
                  a_closed && !start_closed;                  // R8

  // Three-wire direction switch sampled only at a start pulse
  assign three_rev_req = a_start_rev && a_closed;             // R10

  // Latch lives only in the momentary scheme, no stale run on switch
  assign three_sel = (WIRING_SCHEME == SCHEME_THREE_WIRE);

  // Latched run state of the momentary scheme
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_STOPPED: begin
        if (stop_closed && start_pulse) begin                 // R9
          state_next = three_rev_req ? ST_REV : ST_FWD;
        end
      end
      ST_FWD: begin
        if (!stop_closed) begin                               // R9
          state_next = ST_STOPPED;
        end else if (start_pulse && three_rev_req) begin      // R10
          state_next = ST_REV;
        end
      end
      ST_REV: begin
        if (!stop_closed) begin                               // R9
          state_next = ST_STOPPED;
        end else if (start_pulse && !three_rev_req) begin     // R10
          state_next = ST_FWD;
        end
      end
      default: begin
        state_next = ST_STOPPED;
      end
    endcase
    if (!three_sel) begin
      state_next = ST_STOPPED;                                // R9
    end
  end

  // Run and direction chosen by wiring scheme
  always_comb begin
    run_next = 1'b0;
    rev_next = 1'b0;
    case (WIRING_SCHEME)
      SCHEME_TWO_WIRE: begin
        run_next = two_run;                                   // R1
        rev_next = two_run && two_rev;
      end
      SCHEME_FWD_REV: begin
        run_next = fr_fwd || fr_rev;                          // R8
        rev_next = fr_rev;
      end
      SCHEME_THREE_WIRE: begin
        run_next = (state_next != ST_STOPPED);
        rev_next = (state_next == ST_REV);
      end
      default: begin
        run_next = 1'b0;
        rev_next = 1'b0;
      end
    endcase
  end

  // Select input speed roles; A loses preset role when it steers
  assign a_volt = (SELECT_A_FUNCTION == SEL_VOLTAGE_REF);     // R4
  assign a_curr = (SELECT_A_FUNCTION == SEL_CURRENT_REF);
  assign a_pre  = (SELECT_A_FUNCTION == SEL_PRESET);          // R12
  assign b_volt = (SELECT_B_FUNCTION == SEL_VOLTAGE_REF);
  assign b_curr = (SELECT_B_FUNCTION == SEL_CURRENT_REF);
  assign b_pre  = (SELECT_B_FUNCTION == SEL_PRESET);          // R11
  assign c_volt = (SELECT_C_FUNCTION == SEL_VOLTAGE_REF);
  assign c_curr = (SELECT_C_FUNCTION == SEL_CURRENT_REF);
  assign c_pre  = (SELECT_C_FUNCTION == SEL_PRESET);

  assign a_ref = a_closed && (a_volt || a_curr || a_pre);
  assign b_ref = b_closed && (b_volt || b_curr || b_pre);
  assign c_ref = c_closed && (c_volt || c_curr || c_pre);

  // Preset number from closed preset selects, A lowest bit
  assign preset_combo = {c_closed && c_pre,
                         b_closed && b_pre,
                         a_closed && a_pre};                  // R11

  // Standard source decode
  assign std_src = (STD_SPEED_SOURCE == STD_SRC_VOLTAGE) ? SRC_VOLTAGE :
                   (STD_SPEED_SOURCE == STD_SRC_CURRENT) ? SRC_CURRENT :
                   (STD_SPEED_SOURCE == STD_SRC_PRESET1) ? SRC_PRESET :
                   SRC_KEYPAD;                                // R5
  assign std_idx = (STD_SPEED_SOURCE == STD_SRC_PRESET1) ?
                   PRESET_IDX_ONE : PRESET_IDX_NONE;

  // Highest-lettered closed reference select wins
  always_comb begin
    src_next = std_src;                                       // R13
    idx_next = std_idx;
    if (c_ref) begin                                          // R15
      src_next = c_volt ? SRC_VOLTAGE : c_curr ? SRC_CURRENT : SRC_PRESET;
      idx_next = c_pre ? preset_combo : PRESET_IDX_NONE;
    end else if (b_ref) begin                                 // R15
      src_next = b_volt ? SRC_VOLTAGE : b_curr ? SRC_CURRENT : SRC_PRESET;
      idx_next = b_pre ? preset_combo : PRESET_IDX_NONE;
    end else if (a_ref) begin                                 // R4
      src_next = a_volt ? SRC_VOLTAGE : a_curr ? SRC_CURRENT : SRC_PRESET;
      idx_next = a_pre ? preset_combo : PRESET_IDX_NONE;
    end
  end

  // Preset value table, entry zero gives the reset speed
  assign preset_tab[0] = SPEED_RESET;
  assign preset_tab[1] = PRESET_SPEED_1;                      // R14
  assign preset_tab[2] = PRESET_SPEED_2;
  assign preset_tab[3] = PRESET_SPEED_3;
  assign preset_tab[4] = PRESET_SPEED_4;
  assign preset_tab[5] = PRESET_SPEED_5;
  assign preset_tab[6] = PRESET_SPEED_6;
  assign preset_tab[7] = PRESET_SPEED_7;
  assign speed_next    = preset_tab[idx_next];                // R14

  // Run state and edge memory
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_reg      <= ST_STOPPED;
      start_prev_reg <= 1'b0;
    end else if (CE) begin
      state_reg      <= state_next;
      start_prev_reg <= start_closed;
    end
  end

  // Registered command outputs
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      RUN_CMD          <= 1'b0;
      REVERSE_CMD      <= 1'b0;
      SPEED_SOURCE     <= SRC_KEYPAD;
      PRESET_INDEX     <= PRESET_IDX_NONE;
      PRESET_SPEED_OUT <= SPEED_RESET;
    end else if (CE) begin
      RUN_CMD          <= run_next;
      REVERSE_CMD      <= rev_next;
      SPEED_SOURCE     <= src_next;
      PRESET_INDEX     <= idx_next;
      PRESET_SPEED_OUT <= speed_next;
    end
  end

endmodule : drive_run_speed_select

`default_nettype wire

/* sim/contact_bank.sv */
`timescale 1ns/1ps
`default_nettype none

module contact_bank (
  input  wire logic [4:0] closed,
  input  wire logic       tie_start,
  output var  logic       stop_n,
  output var  logic       start_n,
  output var  logic       sel_a_n,
  output var  logic       sel_b_n,
  output var  logic       sel_c_n
);
  // Open contact pulled high, closed contact shorts to common
  assign stop_n  = ~closed[0];
  assign start_n = ~(closed[1] | tie_start);
  assign sel_a_n = ~closed[2];
  assign sel_b_n = ~closed[3];
  assign sel_c_n = ~closed[4];
endmodule : contact_bank

`default_nettype wire

/* sim/drive_run_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module drive_run_monitor #(
  parameter int DEBOUNCE_CYCLES = 4
) (
  input wire logic                          CORE_CLK,
  input wire logic                          RESET,
  input wire logic                          CE,
  input wire logic                          STOP_CONTACT_INPUT_N,
  input wire logic                          START_CONTACT_INPUT_N,
  input wire logic                          SELECT_INPUT_A_N,
  input wire logic                          SELECT_INPUT_C_N,
  input wire logic [1:0]                    WIRING_SCHEME,
  input wire logic [drive_pkg::CODE_W-1:0]  SELECT_C_FUNCTION,
  input wire logic [drive_pkg::SPEED_W-1:0] PRESET_SPEED_3,
  input wire logic                          RUN_CMD,
  input wire logic                          REVERSE_CMD,
  input wire logic [2:0]                    SPEED_SOURCE,
  input wire logic [2:0]                    PRESET_INDEX,
  input wire logic [drive_pkg::SPEED_W-1:0] PRESET_SPEED_OUT
);
  import drive_pkg::*;
  // Repeat counts of 8 cover the 7-edge path of a filter of 4
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET || !CE);

  // Command relations
  property p_stop_open;
    (WIRING_SCHEME == SCHEME_TWO_WIRE && STOP_CONTACT_INPUT_N)[*8]
      |-> !RUN_CMD;
  endproperty
  a_stop_open: assert property (p_stop_open)
    else $error("run with stop contact open");
  property p_fr_both;
    (WIRING_SCHEME == SCHEME_FWD_REV && !START_CONTACT_INPUT_N
     && !SELECT_INPUT_A_N)[*8] |-> !RUN_CMD;
  endproperty
  a_fr_both: assert property (p_fr_both)
    else $error("run with both direction contacts closed");
  property p_fr_fwd;
    (WIRING_SCHEME == SCHEME_FWD_REV && !START_CONTACT_INPUT_N
     && SELECT_INPUT_A_N)[*8] |-> RUN_CMD && !REVERSE_CMD;
  endproperty
  a_fr_fwd: assert property (p_fr_fwd)
    else $error("no forward run with start closed");
  property p_tw_stop;
    (WIRING_SCHEME == SCHEME_THREE_WIRE && STOP_CONTACT_INPUT_N)[*8]
      |-> !RUN_CMD;
  endproperty
  a_tw_stop: assert property (p_tw_stop)
    else $error("latched run survives open stop");
  property p_tw_dir;
    (WIRING_SCHEME == SCHEME_THREE_WIRE && START_CONTACT_INPUT_N)[*8]
      ##0 (RUN_CMD && $past(RUN_CMD)) |-> $stable(REVERSE_CMD);
  endproperty
  a_tw_dir: assert property (p_tw_dir)
    else $error("direction changed without start pulse");
  property p_rev_run;
    REVERSE_CMD |-> RUN_CMD;
  endproperty
  a_rev_run: assert property (p_rev_run)
    else $error("reverse without run");

  // Speed selection relations
  property p_idx_none;
    PRESET_INDEX == PRESET_IDX_NONE |-> PRESET_SPEED_OUT == SPEED_RESET;
  endproperty
  a_idx_none: assert property (p_idx_none)
    else $error("speed output nonzero without preset");
  property p_idx_three;
    PRESET_INDEX == 3'h3 |-> PRESET_SPEED_OUT == $past(PRESET_SPEED_3);
  endproperty
  a_idx_three: assert property (p_idx_three)
    else $error("preset three value not passed");
  property p_idx_src;
    PRESET_INDEX != PRESET_IDX_NONE |-> SPEED_SOURCE == SRC_PRESET;
  endproperty
  a_idx_src: assert property (p_idx_src)
    else $error("preset index without preset source");
  property p_c_first;
    (SELECT_C_FUNCTION == SEL_CURRENT_REF && !SELECT_INPUT_C_N)[*8]
      |-> SPEED_SOURCE == SRC_CURRENT;
  endproperty
  a_c_first: assert property (p_c_first)
    else $error("select C reference not followed");

  // Main scenarios reached
  c_tw_run: cover property (WIRING_SCHEME == SCHEME_THREE_WIRE && RUN_CMD);
  c_rev: cover property (REVERSE_CMD);
  c_idx7: cover property (PRESET_INDEX == 3'h7);
endmodule : drive_run_monitor

bind drive_run_speed_select drive_run_monitor #(
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) i_drive_run_monitor (
  .CORE_CLK, .RESET, .CE, .STOP_CONTACT_INPUT_N, .START_CONTACT_INPUT_N,
  .SELECT_INPUT_A_N, .SELECT_INPUT_C_N, .WIRING_SCHEME, .SELECT_C_FUNCTION,
  .PRESET_SPEED_3, .RUN_CMD, .REVERSE_CMD, .SPEED_SOURCE, .PRESET_INDEX,
  .PRESET_SPEED_OUT
);

`default_nettype wire

/* sim/drive_run_speed_select_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module drive_run_speed_select_tb_top;
  import drive_pkg::*;
  logic        clk       = 1'b0;
  logic        rst       = 1'b1;
  logic        ce        = 1'b1;
  logic [4:0]  closed    = 5'h01; // C B A start stop
  logic        tie_start = 1'b1;
  logic [1:0]  scheme    = SCHEME_TWO_WIRE;
  logic [7:0]  dir       = 8'h00;
  logic [7:0]  std       = 8'h00;
  logic [7:0]  fa        = 8'h00;
  logic [7:0]  fb        = 8'h00;
  logic [7:0]  fc        = 8'h00;
  logic [15:0] pv [1:7];
  logic        stop_n, start_n, a_n, b_n, c_n, run, rev;
  logic [2:0]  src, idx;
  logic [15:0] spd;
  int          n_errors   = 0;
  int          n_compared = 0;

  // Clock and contacts
  always #10 clk = ~clk;
  contact_bank i_contact_bank (.closed(closed), .tie_start(tie_start),
    .stop_n(stop_n), .start_n(start_n), .sel_a_n(a_n), .sel_b_n(b_n),
    .sel_c_n(c_n));
  drive_run_speed_select #(.DEBOUNCE_CYCLES(4)) i_drive_run_speed_select (
    .CORE_CLK(clk), .RESET(rst), .CE(ce), .STOP_CONTACT_INPUT_N(stop_n),
    .START_CONTACT_INPUT_N(start_n), .SELECT_INPUT_A_N(a_n),
    .SELECT_INPUT_B_N(b_n), .SELECT_INPUT_C_N(c_n), .WIRING_SCHEME(scheme),
    .ROTATION_DIRECTION(dir), .STD_SPEED_SOURCE(std),
    .SELECT_A_FUNCTION(fa), .SELECT_B_FUNCTION(fb), .SELECT_C_FUNCTION(fc),
    .PRESET_SPEED_1(pv[1]), .PRESET_SPEED_2(pv[2]), .PRESET_SPEED_3(pv[3]),
    .PRESET_SPEED_4(pv[4]), .PRESET_SPEED_5(pv[5]), .PRESET_SPEED_6(pv[6]),
    .PRESET_SPEED_7(pv[7]), .RUN_CMD(run), .REVERSE_CMD(rev),
    .SPEED_SOURCE(src), .PRESET_INDEX(idx), .PRESET_SPEED_OUT(spd));

  // Comparison and drive helpers
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_cmd(logic r, logic v);
    chk("run", {15'h0, r}, {15'h0, run});
    chk("reverse", {15'h0, v}, {15'h0, rev});
  endtask : chk_cmd
  task automatic chk_spd(logic [2:0] s, logic [2:0] i, logic [15:0] v);
    chk("source", {13'h0, s}, {13'h0, src});
    chk("index", {13'h0, i}, {13'h0, idx});
    chk("speed", v, spd);
  endtask : chk_spd
  task automatic hold(logic [4:0] c, int n);
    @(posedge clk);
    closed <= c;
    repeat (n) @(posedge clk);
    #1;
  endtask : hold

  // Scenarios
  task automatic t_two_wire;
    @(posedge clk);
    #1;
    chk_cmd(1'b0, 1'b0);
    hold(5'h01, 10);
    chk_cmd(1'b1, 1'b0);
    @(posedge clk);
    ce <= 1'b0;
    hold(5'h00, 10);
    chk_cmd(1'b1, 1'b0);
    hold(5'h01, 1);
    @(posedge clk);
    ce <= 1'b1;
    hold(5'h00, 1);
    hold(5'h01, 10);
    chk_cmd(1'b1, 1'b0);
    hold(5'h00, 10);
    chk_cmd(1'b0, 1'b0);
    @(posedge clk);
    tie_start <= 1'b0;
    fa        <= SEL_START_REVERSE;
    hold(5'h05, 10);
    chk_cmd(1'b0, 1'b0);
    @(posedge clk);
    dir <= DIR_FWD_AND_REV;
    hold(5'h05, 10);
    chk_cmd(1'b1, 1'b1);
    hold(5'h01, 10);
    chk_cmd(1'b0, 1'b0);
    $display("test two_wire done");
  endtask : t_two_wire
  task automatic t_fwd_rev;
    @(posedge clk);
    scheme <= SCHEME_FWD_REV;
    fa     <= SEL_RUN_REVERSE;
    hold(5'h03, 10);
    chk_cmd(1'b1, 1'b0);
    hold(5'h05, 10);
    chk_cmd(1'b1, 1'b1);
    hold(5'h07, 10);
    chk_cmd(1'b0, 1'b0);
    hold(5'h01, 10);
    chk_cmd(1'b0, 1'b0);
    @(posedge clk);
    dir <= 8'h00;
    hold(5'h05, 10);
    chk_cmd(1'b0, 1'b0);
    $display("test fwd_rev done");
  endtask : t_fwd_rev
  task automatic t_three_wire;
    @(posedge clk);
    scheme <= SCHEME_THREE_WIRE;
    fa     <= SEL_START_REVERSE;
    dir    <= DIR_FWD_AND_REV;
    hold(5'h01, 10);
    chk_cmd(1'b0, 1'b0);
    hold(5'h03, 10);
    hold(5'h01, 10);
    chk_cmd(1'b1, 1'b0);
    hold(5'h05, 10);
    chk_cmd(1'b1, 1'b0);
    hold(5'h07, 10);
    hold(5'h05, 10);
    chk_cmd(1'b1, 1'b1);
    hold(5'h04, 10);
    hold(5'h05, 10);
    chk_cmd(1'b0, 1'b0);
    $display("test three_wire done");
  endtask : t_three_wire
  task automatic t_speed;
    @(posedge clk);
    scheme <= 2'h3;
    fa     <= SEL_PRESET;
    fb     <= SEL_PRESET;
    fc     <= SEL_PRESET;
    std    <= STD_SRC_VOLTAGE;
    hold(5'h00, 10);
    chk_spd(SRC_VOLTAGE, 3'h0, 16'h0000);
    @(posedge clk);
    std <= STD_SRC_CURRENT;
    hold(5'h00, 10);
    chk_spd(SRC_CURRENT, 3'h0, 16'h0000);
    @(posedge clk);
    std <= STD_SRC_PRESET1;
    hold(5'h00, 10);
    chk_spd(SRC_PRESET, 3'h1, pv[1]);
    for (int i = 1; i <= 7; i++) begin
      hold({3'(i), 2'b00}, 10);
      chk_spd(SRC_PRESET, 3'(i), pv[i]);
    end
    @(posedge clk);
    fa  <= SEL_VOLTAGE_REF;
    std <= 8'h00;
    hold(5'h04, 10);
    chk_spd(SRC_VOLTAGE, 3'h0, 16'h0000);
    hold(5'h00, 10);
    chk_spd(SRC_KEYPAD, 3'h0, 16'h0000);
    hold(5'h14, 10);
    chk_spd(SRC_PRESET, 3'h4, pv[4]);
    @(posedge clk);
    fc <= SEL_CURRENT_REF;
    hold(5'h14, 10);
    chk_spd(SRC_CURRENT, 3'h0, 16'h0000);
    @(posedge clk);
    fa <= SEL_RUN_REVERSE;
    fc <= SEL_PRESET;
    hold(5'h0C, 10);
    chk_spd(SRC_PRESET, 3'h2, pv[2]);
    $display("test speed done");
  endtask : t_speed

  // Verdict and end of run
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    for (int i = 1; i <= 7; i++) pv[i] = 16'h1000 + 16'(i);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_two_wire;
    t_fwd_rev;
    t_three_wire;
    t_speed;
    end_of_test;
  end

  // Watchdog well past the expected run
  initial begin
    #200000;
    n_errors++;
    end_of_test;
  end
endmodule : drive_run_speed_select_tb_top

`default_nettype wire
